// [hdl/bsu_monitor.sv]
// Local design decisions: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
module bsu_monitor
	import bsu_pkg::*;
#(
	parameter int         PWR_W     = 16,
	parameter logic [15:0] RATED_RST = 16'h03E8
)
(
	input  wire logic             aclk,
	input  wire logic             aresetn,
	// axi4-lite slave
	input  wire logic [7:0]       s_axi_awaddr,
	input  wire logic             s_axi_awvalid,
	output logic                  s_axi_awready,
	input  wire logic [31:0]      s_axi_wdata,
	input  wire logic [3:0]       s_axi_wstrb,
	input  wire logic             s_axi_wvalid,
	output logic                  s_axi_wready,
	output logic [1:0]            s_axi_bresp,
	output logic                  s_axi_bvalid,
	input  wire logic             s_axi_bready,
	input  wire logic [7:0]       s_axi_araddr,
	input  wire logic             s_axi_arvalid,
	output logic                  s_axi_arready,
	output logic [31:0]           s_axi_rdata,
	output logic [1:0]            s_axi_rresp,
	output logic                  s_axi_rvalid,
	input  wire logic             s_axi_rready,
	// breaker sequencer, same clock
	input  wire logic             sec_tick,
	input  wire logic             sync_start,
	input  wire logic             sync_done,
	input  wire logic             sync_abort,
	input  wire logic             unload_start,
	input  wire logic             unload_abort,
	input  wire logic [PWR_W-1:0] system_b_power,
	// pins
	input  wire logic             lock_monitoring_pin,
	input  wire logic             front_ack_pin,
	input  wire logic             ext_ack_pin,
	// results
	output logic                  system_b_breaker_open,
	output bsu_alarm_t            alarms,
	output logic                  irq
);

	localparam int PW = PWR_W + 10;

	bsu_state_t   s_st_q, s_st_d, u_st_q, u_st_d;
	logic [9:0]   s_cnt_q, s_cnt_d, u_cnt_q, u_cnt_d;
	logic         s_alm_q, s_alm_d, u_alm_q, u_alm_d;
	logic         open_q, open_d;
	logic [31:0]  ctrl_q, ctrl_d;
	logic [9:0]   sdly_q, sdly_d, udly_q, udly_d, trip_q, trip_d;
	logic [15:0]  rated_q, rated_d;
	logic [BSU_NEV-1:0] stat_q, stat_d, mask_q, mask_d, ev;
	logic [2:0]   lk_q, fa_q, ea_q;
	logic         aw_q, aw_d, w_q, w_d, b_q, b_d, r_q, r_d;
	logic [7:0]   awa_q, awa_d;
	logic [31:0]  wd_q, wd_d, rd_q, rd_d;
	logic [1:0]   br_q, br_d, rr_q, rr_d;
	logic         lock, ack, s_eval, u_eval, below, wr_go, rd_go;
	logic [31:0]  wv, rv;
	logic         rv_ok;
	bsu_mon_cfg_t scfg, ucfg;

	// pin synchronisers: two stages, the third only feeds the ack edge
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			lk_q <= 3'h0;
			fa_q <= 3'h0;
			ea_q <= 3'h0;
		end
		else
		begin
			lk_q <= {lk_q[1:0], lock_monitoring_pin};
			fa_q <= {fa_q[1:0], front_ack_pin};
			ea_q <= {ea_q[1:0], ext_ack_pin};
		end
	end

	// ack edge of either source so a held button acts once
	always_comb
	begin
		lock = lk_q[1];
		ack  = (fa_q[1] & ~fa_q[2]) | (ea_q[1] & ~ea_q[2]);
	end

	// configuration views
	always_comb
	begin
		scfg.en          = ctrl_q[BSU_C_SYNC_EN];
		scfg.self_ack    = ctrl_q[BSU_C_SYNC_SACK];
		scfg.lockable    = ctrl_q[BSU_C_SYNC_LOCK];
		scfg.alarm_class = ctrl_q[BSU_C_SYNC_CLS +: 3];
		ucfg.en          = ctrl_q[BSU_C_UNL_EN];
		ucfg.self_ack    = ctrl_q[BSU_C_UNL_SACK];
		ucfg.lockable    = ctrl_q[BSU_C_UNL_LOCK];
		ucfg.alarm_class = ctrl_q[BSU_C_UNL_CLS +: 3];
		// lock flag only matters for a lockable monitor
		s_eval = scfg.en & ~(scfg.lockable & lock);
		u_eval = ucfg.en & ~(ucfg.lockable & lock);
	end

	// power * 1000 < trip * rated, both in power units
	always_comb
	begin
		below = (PW'(system_b_power) * PW'(BSU_PERMILLE))
			< (PW'(trip_q) * PW'(rated_q));
	end

	// synchronisation timeout monitor
	always_comb
	begin
		s_st_d  = s_st_q;
		s_cnt_d = s_cnt_q;
		s_alm_d = s_alm_q;
		case (s_st_q)
			BSU_IDLE:
			begin
				s_cnt_d = '0;
				if (sync_start)
					s_st_d = BSU_RUN;
			end
			BSU_RUN:
			begin
				if (sync_done | sync_abort)
				begin
					s_st_d  = BSU_IDLE;
					s_cnt_d = '0;
				end
				else
				begin
					if (sec_tick && s_cnt_q != BSU_DLY_MAX)
						s_cnt_d = s_cnt_q + 10'h001;
					if (s_eval && s_cnt_q >= sdly_q)
						s_st_d = BSU_EXP;
				end
			end
			BSU_EXP:
			begin
				if (sync_done | sync_abort)
				begin
					s_st_d  = BSU_IDLE;
					s_cnt_d = '0;
				end
			end
			default:
				s_st_d = BSU_IDLE;
		endcase
		// entering expiry raises alarm; set wins over any clear
		if (s_st_q == BSU_RUN && s_st_d == BSU_EXP)
			s_alm_d = 1'b1;
		else if (!scfg.en)
			s_alm_d = 1'b0;
		else if (s_st_q != BSU_EXP && (scfg.self_ack || ack))
			s_alm_d = 1'b0;
	end

	// unload monitor and breaker open command
	always_comb
	begin
		u_st_d  = u_st_q;
		u_cnt_d = u_cnt_q;
		u_alm_d = u_alm_q;
		open_d  = 1'b0;
		case (u_st_q)
			BSU_IDLE:
			begin
				u_cnt_d = '0;
				if (unload_start)
					u_st_d = BSU_RUN;
			end
			BSU_RUN:
			begin
				if (unload_abort)
				begin
					u_st_d  = BSU_IDLE;
					u_cnt_d = '0;
				end
				else if (below)
				begin
					open_d  = 1'b1;
					u_st_d  = BSU_IDLE;
					u_cnt_d = '0;
				end
				else if (u_eval && u_cnt_q >= udly_q)
				begin
					open_d = 1'b1;
					u_st_d = BSU_EXP;
				end
				else if (sec_tick && u_cnt_q != BSU_DLY_MAX)
					u_cnt_d = u_cnt_q + 10'h001;
			end
			BSU_EXP:
			begin
				// fault stands until a new unload or an abort
				if (unload_start | unload_abort)
				begin
					u_st_d  = unload_start ? BSU_RUN : BSU_IDLE;
					u_cnt_d = '0;
				end
			end
			default:
				u_st_d = BSU_IDLE;
		endcase
		if (u_st_q == BSU_RUN && u_st_d == BSU_EXP)
			u_alm_d = 1'b1;
		else if (!ucfg.en)
			u_alm_d = 1'b0;
		else if (u_st_q != BSU_EXP && (ucfg.self_ack || ack))
			u_alm_d = 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_st_q  <= BSU_IDLE;
			u_st_q  <= BSU_IDLE;
			s_cnt_q <= '0;
			u_cnt_q <= '0;
			s_alm_q <= 1'b0;
			u_alm_q <= 1'b0;
			open_q  <= 1'b0;
		end
		else
		begin
			s_st_q  <= s_st_d;
			u_st_q  <= u_st_d;
			s_cnt_q <= s_cnt_d;
			u_cnt_q <= u_cnt_d;
			s_alm_q <= s_alm_d;
			u_alm_q <= u_alm_d;
			open_q  <= open_d;
		end
	end

	// alarm outputs; the logic flags follow the latched alarms
	always_comb
	begin
		alarms.sync_timeout_alarm    = s_alm_q;
		alarms.unload_mismatch_alarm = u_alm_q;
		alarms.sync_class            = scfg.alarm_class;
		alarms.unload_class          = ucfg.alarm_class;
		system_b_breaker_open        = open_q;
		irq                          = |(stat_q & mask_q);
	end

	// bus: write address and data taken independently, then one response
	always_comb
	begin
		aw_d  = aw_q;
		w_d   = w_q;
		b_d   = b_q;
		awa_d = awa_q;
		wd_d  = wd_q;
		br_d  = br_q;
		if (s_axi_awvalid && !aw_q)
		begin
			aw_d  = 1'b1;
			awa_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && !w_q)
		begin
			w_d = 1'b1;
			// whole data word latched here; byte lanes are merged against wstrb at the register write
			wd_d = s_axi_wdata;
		end
		wr_go = aw_q && w_q && !b_q;
		if (wr_go)
		begin
			aw_d = 1'b0;
			w_d  = 1'b0;
			b_d  = 1'b1;
			br_d = (awa_q[7:2] <= BSU_OFF_STATE[7:2] && awa_q[1:0] == 2'b00)
				? 2'b00 : 2'b10;
		end
		else if (b_q && s_axi_bready)
			b_d = 1'b0;
		s_axi_awready = !aw_q;
		s_axi_wready  = !w_q;
		s_axi_bvalid  = b_q;
		s_axi_bresp   = br_q;
	end

	// merge strobes with the current value of the addressed register
	always_comb
	begin
		case (awa_q)
			BSU_OFF_CTRL:  rv = ctrl_q;
			BSU_OFF_SDLY:  rv = {22'h0, sdly_q};
			BSU_OFF_UDLY:  rv = {22'h0, udly_q};
			BSU_OFF_TRIP:  rv = {22'h0, trip_q};
			BSU_OFF_RATED: rv = {16'h0, rated_q};
			BSU_OFF_MASK:  rv = {29'h0, mask_q};
			default:       rv = 32'h0000_0000;
		endcase
		for (int i = 0; i < 4; i++)
			wv[8*i +: 8] = s_axi_wstrb[i] ? wd_q[8*i +: 8] : rv[8*i +: 8];
	end

	// register writes, settings clamped into their ranges
	always_comb
	begin
		ctrl_d  = ctrl_q;
		sdly_d  = sdly_q;
		udly_d  = udly_q;
		trip_d  = trip_q;
		rated_d = rated_q;
		mask_d  = mask_q;
		if (wr_go)
		begin
			case (awa_q)
				BSU_OFF_CTRL:
					ctrl_d = wv & 32'h0000_773F;
				BSU_OFF_SDLY:
					sdly_d = (wv[9:0] < BSU_SDLY_MIN) ? BSU_SDLY_MIN :
						(wv[9:0] > BSU_DLY_MAX) ? BSU_DLY_MAX : wv[9:0];
				BSU_OFF_UDLY:
					udly_d = (wv[9:0] < BSU_UDLY_MIN) ? BSU_UDLY_MIN :
						(wv[9:0] > BSU_DLY_MAX) ? BSU_DLY_MAX : wv[9:0];
				BSU_OFF_TRIP:
					trip_d = (wv[9:0] < BSU_TRIP_MIN) ? BSU_TRIP_MIN :
						(wv[9:0] > BSU_TRIP_MAX) ? BSU_TRIP_MAX : wv[9:0];
				BSU_OFF_RATED:
					rated_d = wv[15:0];
				BSU_OFF_MASK:
					mask_d = wv[BSU_NEV-1:0];
				default:
					mask_d = mask_q;
			endcase
			// class codes above Control fold back to the default
			if (awa_q == BSU_OFF_CTRL)
			begin
				if (wv[BSU_C_SYNC_CLS +: 3] > BSU_CLS_CTRL)
					ctrl_d[BSU_C_SYNC_CLS +: 3] = BSU_CLS_B;
				if (wv[BSU_C_UNL_CLS +: 3] > BSU_CLS_CTRL)
					ctrl_d[BSU_C_UNL_CLS +: 3] = BSU_CLS_B;
			end
		end
	end

	// read channel; a status read clears, new events win over the clear
	always_comb
	begin
		r_d   = r_q;
		rd_d  = rd_q;
		rr_d  = rr_q;
		rd_go = s_axi_arvalid && !r_q;
		rv_ok = 1'b1;
		case (s_axi_araddr)
			BSU_OFF_CTRL:   rd_d = ctrl_q;
			BSU_OFF_SDLY:   rd_d = {22'h0, sdly_q};
			BSU_OFF_UDLY:   rd_d = {22'h0, udly_q};
			BSU_OFF_TRIP:   rd_d = {22'h0, trip_q};
			BSU_OFF_RATED:  rd_d = {16'h0, rated_q};
			BSU_OFF_STATUS: rd_d = {29'h0, stat_q};
			BSU_OFF_MASK:   rd_d = {29'h0, mask_q};
			BSU_OFF_STATE:  rd_d = {4'h0, u_cnt_q, s_cnt_q,
				u_st_q, s_st_q, u_alm_q, s_alm_q};
			default:
			begin
				rd_d  = 32'h0000_0000;
				rv_ok = 1'b0;
			end
		endcase
		if (rd_go)
		begin
			r_d  = 1'b1;
			rr_d = rv_ok ? 2'b00 : 2'b10;
		end
		else
		begin
			rd_d = rd_q;
			if (r_q && s_axi_rready)
				r_d = 1'b0;
		end
		// all event bits built here so the vector has a single writer
		ev[BSU_S_SYNC_TO]  = (s_st_q == BSU_RUN) && (s_st_d == BSU_EXP);
		ev[BSU_S_UNL_MIS]  = (u_st_q == BSU_RUN) && (u_st_d == BSU_EXP);
		ev[BSU_S_UNL_TRIP] = open_d && (u_st_d == BSU_IDLE);
		stat_d = stat_q;
		if (rd_go && s_axi_araddr == BSU_OFF_STATUS)
			stat_d = '0;
		stat_d = stat_d | ev;
		s_axi_arready = !r_q;
		s_axi_rvalid  = r_q;
		s_axi_rdata   = rd_q;
		s_axi_rresp   = rr_q;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_q    <= 1'b0;
			w_q     <= 1'b0;
			b_q     <= 1'b0;
			r_q     <= 1'b0;
			awa_q   <= '0;
			wd_q    <= '0;
			rd_q    <= '0;
			br_q    <= 2'b00;
			rr_q    <= 2'b00;
			ctrl_q  <= BSU_CTRL_RST;
			sdly_q  <= BSU_SDLY_RST;
			udly_q  <= BSU_UDLY_RST;
			trip_q  <= BSU_TRIP_RST;
			rated_q <= RATED_RST;
			stat_q  <= '0;
			mask_q  <= '0;
		end
		else
		begin
			aw_q    <= aw_d;
			w_q     <= w_d;
			b_q     <= b_d;
			r_q     <= r_d;
			awa_q   <= awa_d;
			wd_q    <= wd_d;
			rd_q    <= rd_d;
			br_q    <= br_d;
			rr_q    <= rr_d;
			ctrl_q  <= ctrl_d;
			sdly_q  <= sdly_d;
			udly_q  <= udly_d;
			trip_q  <= trip_d;
			rated_q <= rated_d;
			stat_q  <= stat_d;
			mask_q  <= mask_d;
		end
	end

endmodule

// [shared/bsu_pkg.sv]
package bsu_pkg;

	// register byte offsets
	localparam logic [7:0] BSU_OFF_CTRL   = 8'h00;
	localparam logic [7:0] BSU_OFF_SDLY   = 8'h04;
	localparam logic [7:0] BSU_OFF_UDLY   = 8'h08;
	localparam logic [7:0] BSU_OFF_TRIP   = 8'h0C;
	localparam logic [7:0] BSU_OFF_RATED  = 8'h10;
	localparam logic [7:0] BSU_OFF_STATUS = 8'h14;
	localparam logic [7:0] BSU_OFF_MASK   = 8'h18;
	localparam logic [7:0] BSU_OFF_STATE  = 8'h1C;

	// control field positions
	localparam int BSU_C_SYNC_EN   = 0;
	localparam int BSU_C_SYNC_SACK = 1;
	localparam int BSU_C_SYNC_LOCK = 2;
	localparam int BSU_C_UNL_EN    = 3;
	localparam int BSU_C_UNL_SACK  = 4;
	localparam int BSU_C_UNL_LOCK  = 5;
	localparam int BSU_C_SYNC_CLS  = 8;
	localparam int BSU_C_UNL_CLS   = 12;

	// status / mask bit positions
	localparam int BSU_S_SYNC_TO  = 0;
	localparam int BSU_S_UNL_MIS  = 1;
	localparam int BSU_S_UNL_TRIP = 2;
	localparam int BSU_NEV        = 3;

	// alarm class codes
	localparam logic [2:0] BSU_CLS_A    = 3'h0;
	localparam logic [2:0] BSU_CLS_B    = 3'h1;
	localparam logic [2:0] BSU_CLS_CTRL = 3'h6;

	// reset values and setting limits (seconds, per mille)
	localparam logic [31:0] BSU_CTRL_RST  = 32'h0000_1109;
	localparam logic [9:0]  BSU_SDLY_RST  = 10'h03C;
	localparam logic [9:0]  BSU_SDLY_MIN  = 10'h003;
	localparam logic [9:0]  BSU_UDLY_RST  = 10'h01E;
	localparam logic [9:0]  BSU_UDLY_MIN  = 10'h001;
	localparam logic [9:0]  BSU_DLY_MAX   = 10'h3E7;
	localparam logic [9:0]  BSU_TRIP_RST  = 10'h01E;
	localparam logic [9:0]  BSU_TRIP_MIN  = 10'h005;
	localparam logic [9:0]  BSU_TRIP_MAX  = 10'h3E7;
	localparam logic [9:0]  BSU_PERMILLE  = 10'h3E8;

	// monitor sequencing states
	typedef enum logic [2:0] {
		BSU_IDLE = 3'b001,
		BSU_RUN  = 3'b010,
		BSU_EXP  = 3'b100
	} bsu_state_t;

	// per-monitor configuration
	typedef struct packed {
		logic       en;
		logic       self_ack;
		logic       lockable;
		logic [2:0] alarm_class;
	} bsu_mon_cfg_t;

	// alarm outputs towards the rest of the controller
	typedef struct packed {
		logic       sync_timeout_alarm;
		logic       unload_mismatch_alarm;
		logic [2:0] sync_class;
		logic [2:0] unload_class;
	} bsu_alarm_t;

endpackage

// [tb/bsu_far_model.sv]
`timescale 1ns/1ps
// far side: second tick, power meter, external ack
module bsu_far_model
#(
	parameter int TICK = 8
)
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [15:0] pwr_set,
	input  wire logic        ack_req,
	input  wire logic        system_b_breaker_open,
	output logic             sec_tick,
	output logic [15:0]      system_b_power,
	output logic             ext_ack_pin,
	output int               n_open
);
	int cnt_q;
	// a second shrunk to TICK clocks to keep the run short
	always_ff @(posedge aclk)
	begin
		cnt_q <= (!aresetn || cnt_q == TICK - 1) ? 0 : cnt_q + 1;
		sec_tick <= aresetn && cnt_q == TICK - 1;
		system_b_power <= pwr_set;
		ext_ack_pin <= ack_req;
		n_open <= aresetn ? n_open + int'(system_b_breaker_open) : 0;
	end
endmodule

// [tb/bsu_monitor_checker.sv]
`timescale 1ns/1ps
module bsu_monitor_checker
	import bsu_pkg::*;
(
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        system_b_breaker_open,
	input wire bsu_alarm_t  alarms,
	input wire logic        irq
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// both write channels taken at one edge
	sequence wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence rd_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	// reset check must not be masked by reset itself
	a_reset_quiet: assert property (disable iff (1'b0) !aresetn |=>
		!s_axi_bvalid && !s_axi_rvalid && !irq && alarms == 8'h09 &&
		!system_b_breaker_open) else $error("outputs not at reset");
	a_wr_answer: assert property (wr_take |-> ##[1:2] s_axi_bvalid)
		else $error("write not answered");
	a_rd_answer: assert property (rd_take |=> s_axi_rvalid)
		else $error("read not answered");
	a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid) else $error("bvalid dropped early");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read moved");
	a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while pending");
	a_bresp_code: assert property (s_axi_bvalid |->
		s_axi_bresp inside {2'b00, 2'b10}) else $error("bad bresp");
	a_open_pulse: assert property (system_b_breaker_open
		|=> !system_b_breaker_open) else $error("open pulse too long");
	a_mismatch_opens: assert property (
		$rose(alarms.unload_mismatch_alarm) |-> system_b_breaker_open)
		else $error("mismatch alarm without open");
	a_class_legal: assert property (
		alarms.sync_class <= BSU_CLS_CTRL &&
		alarms.unload_class <= BSU_CLS_CTRL) else $error("bad class code");
endmodule
bind bsu_monitor bsu_monitor_checker chk (.aclk, .aresetn, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
	.s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .system_b_breaker_open,
	.alarms, .irq);

// [tb/bsu_monitor_tb_top.sv]
`timescale 1ns/1ps
module bsu_monitor_tb_top;
	import bsu_pkg::*;
	logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0;
	logic s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0, sync_start = 1'b0, sync_done = 1'b0;
	logic sync_abort = 1'b0, unload_start = 1'b0, unload_abort = 1'b0;
	logic lock_monitoring_pin = 1'b0, front_ack_pin = 1'b0, ack_req = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rd;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, ext_ack_pin, sec_tick, system_b_breaker_open, irq;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [15:0] system_b_power, pwr_set = 16'h07D0;
	bsu_alarm_t alarms;
	int n_errors = 0, tests_run = 0, n_open, t;
	always #25 aclk = ~aclk;
	bsu_monitor dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sec_tick, .sync_start,
		.sync_done, .sync_abort, .unload_start, .unload_abort,
		.system_b_power, .lock_monitoring_pin, .front_ack_pin, .ext_ack_pin,
		.system_b_breaker_open, .alarms, .irq);
	bsu_far_model far (.aclk, .aresetn, .pwr_set, .ack_req,
		.system_b_breaker_open, .sec_tick, .system_b_power, .ext_ack_pin,
		.n_open);
	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			n_errors++;
			$display("Error %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task end_of_test;
		$display("errors %0d compares %0d", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// each channel released at the edge that takes it; settled values
	// are read on the falling edge so the launching edge is never raced
	task axw(input logic [7:0] a, input logic [31:0] d);
		int k;
		logic aw_hs, w_hs, b_hs;
		k = 0;
		b_hs = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		while (k < 40 && !b_hs)
		begin
			@(negedge aclk);
			k++;
			aw_hs = s_axi_awvalid && s_axi_awready;
			w_hs = s_axi_wvalid && s_axi_wready;
			b_hs = s_axi_bready && s_axi_bvalid;
			if (b_hs)
				chk(s_axi_bresp, 0);
			@(posedge aclk);
			if (aw_hs)
				s_axi_awvalid <= 1'b0;
			if (w_hs)
				s_axi_wvalid <= 1'b0;
			if (b_hs)
				s_axi_bready <= 1'b0;
		end
		chk(k < 40, 1);
		// idle edge so a next call never re-raises a just released signal
		@(posedge aclk);
	endtask
	task axr(input logic [7:0] a, input logic [1:0] er);
		int k;
		logic ar_hs, r_hs;
		k = 0;
		r_hs = 1'b0;
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		while (k < 40 && !r_hs)
		begin
			@(negedge aclk);
			k++;
			ar_hs = s_axi_arvalid && s_axi_arready;
			r_hs = s_axi_rready && s_axi_rvalid;
			if (r_hs)
				rd = s_axi_rdata;
			if (r_hs)
				chk(s_axi_rresp, er);
			@(posedge aclk);
			if (ar_hs)
				s_axi_arvalid <= 1'b0;
			if (r_hs)
				s_axi_rready <= 1'b0;
		end
		chk(k < 40, 1);
		@(posedge aclk);
	endtask
	// pulses start just after a tick so counts are whole
	task pulse(input int w);
		do @(negedge aclk); while (sec_tick !== 1'b1);
		@(posedge aclk);
		{sync_start, sync_done, sync_abort, unload_start, unload_abort}
			<= 5'h10 >> w;
		@(posedge aclk);
		{sync_start, sync_done, sync_abort, unload_start, unload_abort}
			<= 5'h00;
	endtask
	// ticks and alarm looked at mid-cycle; returns on a rising edge
	task wait_al(input logic w, input int lim);
		t = 0;
		for (int k = 0; k < lim; k++)
		begin
			@(negedge aclk);
			if (sec_tick === 1'b1)
				t++;
			if ((w ? alarms.unload_mismatch_alarm
				: alarms.sync_timeout_alarm) === 1'b1)
				break;
		end
		@(posedge aclk);
	endtask
	task ack(input logic ext);
		if (ext) ack_req <= 1'b1;
		else front_ack_pin <= 1'b1;
		repeat (6) @(posedge aclk);
		{ack_req, front_ack_pin} <= 2'h0;
		repeat (6) @(posedge aclk);
	endtask
	task sync_run(input logic [31:0] c, input logic l, input int lim);
		axw(BSU_OFF_CTRL, c);
		lock_monitoring_pin <= l;
		pulse(0);
		wait_al(1'b0, lim);
	endtask
	task t_reset;
		axr(BSU_OFF_CTRL, 2'h0);
		chk(rd, 32'h0000_1109);
		axr(BSU_OFF_SDLY, 2'h0);
		chk(rd, 32'h0000_003C);
		axr(BSU_OFF_UDLY, 2'h0);
		chk(rd, 32'h0000_001E);
		axr(BSU_OFF_TRIP, 2'h0);
		chk(rd, 32'h0000_001E);
		axr(8'h40, 2'h2);
		chk({alarms.sync_class, alarms.unload_class}, 6'h09);
		axw(BSU_OFF_SDLY, 32'h0000_0001);
		axr(BSU_OFF_SDLY, 2'h0);
		chk(rd, 32'h0000_0003);
	endtask
	task t_sync;
		axw(BSU_OFF_MASK, 32'h0000_0003);
		sync_run(32'h0000_1109, 1'b0, 200);
		chk(t, 3);
		chk(alarms.sync_timeout_alarm, 1);
		chk(irq, 1);
		pulse(1);
		repeat (20) @(posedge aclk);
		chk(alarms.sync_timeout_alarm, 1);
		ack(1'b1);
		chk(alarms.sync_timeout_alarm, 0);
		axr(BSU_OFF_STATUS, 2'h0);
		chk(rd, 1);
		axr(BSU_OFF_STATUS, 2'h0);
		chk(rd, 0);
		chk(irq, 0);
	endtask
	// disabled, locked, then non-lockable with self-ack
	task t_gate;
		sync_run(32'h0000_1108, 1'b0, 120);
		chk(alarms.sync_timeout_alarm, 0);
		pulse(2);
		sync_run(32'h0000_110D, 1'b1, 120);
		chk(alarms.sync_timeout_alarm, 0);
		lock_monitoring_pin <= 1'b0;
		wait_al(1'b0, 40);
		chk(alarms.sync_timeout_alarm, 1);
		pulse(2);
		ack(1'b0);
		chk(alarms.sync_timeout_alarm, 0);
		sync_run(32'h0000_110B, 1'b1, 120);
		chk(alarms.sync_timeout_alarm, 1);
		pulse(1);
		repeat (6) @(posedge aclk);
		chk(alarms.sync_timeout_alarm, 0);
	endtask
	// threshold 30 per mille of 2000 is 60: 60 holds, 59 trips
	task t_unl;
		int o;
		axw(BSU_OFF_RATED, 32'h0000_07D0);
		axr(BSU_OFF_STATUS, 2'h0);
		pwr_set <= 16'h003C;
		o = n_open;
		pulse(3);
		repeat (24) @(posedge aclk);
		chk(n_open - o, 0);
		pwr_set <= 16'h003B;
		repeat (6) @(posedge aclk);
		chk(n_open - o, 1);
		chk(alarms.unload_mismatch_alarm, 0);
		axr(BSU_OFF_STATUS, 2'h0);
		chk(rd, 4);
	endtask
	task t_mis;
		int o;
		axw(BSU_OFF_UDLY, 32'h0000_0002);
		pwr_set <= 16'h07D0;
		o = n_open;
		pulse(3);
		pulse(4);
		repeat (40) @(posedge aclk);
		chk(n_open - o, 0);
		pulse(3);
		wait_al(1'b1, 100);
		// the open counter of the far model trails the pulse by an edge
		@(posedge aclk);
		chk(t, 2);
		chk(n_open - o, 1);
		chk(irq, 1);
		// unload alarm set, unload expired, sync idle, unload count 2
		axr(BSU_OFF_STATE, 2'h0);
		chk(rd, 32'h0008_0086);
		axw(BSU_OFF_CTRL, 32'h0000_1119);
		pulse(4);
		repeat (6) @(posedge aclk);
		chk(alarms.unload_mismatch_alarm, 0);
		axr(BSU_OFF_STATUS, 2'h0);
		chk(rd, 2);
	endtask
	task t_cls;
		for (int i = 0; i < 8; i++)
		begin
			axw(BSU_OFF_CTRL, 32'h0000_0009 | (i << 8) | (i << 12));
			chk({alarms.sync_class, alarms.unload_class},
				i < 7 ? {i[2:0], i[2:0]} : 6'h09);
		end
	endtask
	initial
	begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_reset;
		t_sync;
		t_gate;
		t_unl;
		t_mis;
		t_cls;
		end_of_test;
	end
	// watchdog well past the expected run of under a thousand cycles
	initial
	begin
		repeat (8000) @(posedge aclk);
		n_errors++;
		end_of_test;
	end
endmodule
